// ### hdl/adc_cfg_pkg.sv
// Constants for the gain, chop and current-detect configuration registers.
// Assumes a 16-bit register port with a 4-bit word address.
package adc_cfg_pkg;

    // ****************************************
    // Register port geometry
    // ****************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int REG_COUNT = 3;

    // Printed register addresses.
    localparam logic [3:0] GAIN_SEL_ADDR = 4'h4;
    localparam logic [3:0] SPARE_ADDR = 4'h5;
    localparam logic [3:0] CHOP_CD_ADDR = 4'h6;

    // Slots of the three words inside the register store.
    localparam logic [1:0] GAIN_SEL_IDX = 2'h0;
    localparam logic [1:0] SPARE_IDX = 2'h1;
    localparam logic [1:0] CHOP_CD_IDX = 2'h2;

    // Values after reset.
    localparam logic [15:0] GAIN_SEL_RST = 16'h0000;
    localparam logic [15:0] SPARE_RST = 16'h0000;
    localparam logic [15:0] CHOP_CD_RST = 16'h0600;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int GAIN_CODE_W = 3;
    localparam int CH0_GAIN_LSB = 0;
    localparam int CH1_GAIN_LSB = 4;
    localparam int CH2_GAIN_LSB = 8;
    localparam int CH3_GAIN_LSB = 12;
    localparam int CHOP_DLY_LSB = 9;
    localparam int CHOP_DLY_W = 4;
    localparam int CHOP_EN_BIT = 8;
    localparam int CD_RULE_BIT = 7;
    localparam int CD_NUM_LSB = 4;
    localparam int CD_LEN_LSB = 1;
    localparam int CD_CODE_W = 3;
    localparam int DETECT_MODE_ENABLE_BIT = 0;

    // ****************************************
    // Counts
    // ****************************************
    localparam int CHOP_CNT_W = 17;
    localparam logic [16:0] CHOP_DLY_BASE = 17'h00002;
    localparam logic [7:0] GAIN_UNITY = 8'h01;
    localparam logic [7:0] EXCEED_UNITY = 8'h01;
    localparam int CD_LEN_W = 12;
    localparam logic [11:0] CD_LEN_0 = 12'h080;
    localparam logic [11:0] CD_LEN_1 = 12'h100;
    localparam logic [11:0] CD_LEN_2 = 12'h200;
    localparam logic [11:0] CD_LEN_3 = 12'h300;
    localparam logic [11:0] CD_LEN_4 = 12'h500;
    localparam logic [11:0] CD_LEN_5 = 12'h700;
    localparam logic [11:0] CD_LEN_6 = 12'hA00;
    localparam logic [11:0] CD_LEN_7 = 12'hE00;

    // Global-chop sequencer states.
    typedef enum logic [1:0] {
        CHOP_IDLE = 2'b01,
        CHOP_WAIT = 2'b10
    } chop_state_type;

endpackage

// ### hdl/cfg_word_store.sv
// Small register store with one write port and a registered read port.
// Assumes synchronous, active-low reset and one-cycle strobes.
`timescale 1ns/1ps
module cfg_word_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 3,
    parameter logic [WIDTH*DEPTH-1:0] RST_VALS = '0
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_idx_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [1:0] rd_idx_i,
    output logic [WIDTH-1:0] rd_data_o,
    output logic [WIDTH*DEPTH-1:0] words_o
);

    // Two index bits address at most four words.
    if (DEPTH < 1 || DEPTH > 4) begin : g_depth_check
        $error("cfg_word_store: DEPTH must lie in 1..4");
    end

    // ****************************************
    // Storage
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_word
            // Each word keeps the last value written, reserved bits too.
            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    words_o[g*WIDTH +: WIDTH] <= RST_VALS[g*WIDTH +: WIDTH];
                end else if (wr_en_i && wr_idx_i == 2'(g)) begin
                    words_o[g*WIDTH +: WIDTH] <= wr_data_i;
                end
            end
        end
    endgenerate

    // Read data stand for one cycle after the strobe, zero otherwise.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else if (rd_en_i && int'(rd_idx_i) < DEPTH) begin
            rd_data_o <= words_o[int'(rd_idx_i)*WIDTH +: WIDTH];
        end else begin
            rd_data_o <= '0;
        end
    end

endmodule // cfg_word_store

// ### hdl/adc_gain_chop_regs.sv
// Gain, global-chop and current-detect configuration registers with the
// small sequencers they steer.
// Assumes a host register port in the core clock domain and modulator and
// conversion ticks that are one-cycle pulses synchronous to core_clk_i.
`timescale 1ns/1ps

// Summary of operation
// - Channel 3 gain code sits in bits 14:12, codes give gain 1..128.
// - Channel 2 gain code sits in bits 10:8, same encoding, reset gain 1.
// - Channel 1 gain code sits in bits 6:4, same encoding, reset gain 1.
// - Channel 0 gain code sits in bits 2:0, same encoding, reset gain 1.
// - Gain register lives at address 4h and reads 0000h after reset.
// - Chop and detect register at 6h, reset 0600h, fields as laid out.
// - Wait 2 to 65536 modulator periods, by code, before chop measurement.
// - Rule bit clear: any channel triggers; set: all channels must exceed.
// - Detection needs 1 to 128 exceedances, by power-of-two code.
// - Each detect measurement runs 128 to 3584 conversion periods.
module adc_gain_chop_regs
    import adc_cfg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic [GAIN_CODE_W-1:0] ch0_amp_gain_code_o,
    output logic [GAIN_CODE_W-1:0] ch1_amp_gain_code_o,
    output logic [GAIN_CODE_W-1:0] ch2_amp_gain_code_o,
    output logic [GAIN_CODE_W-1:0] ch3_amp_gain_code_o,
    output logic [7:0] ch0_gain_factor_o,
    output logic [7:0] ch1_gain_factor_o,
    output logic [7:0] ch2_gain_factor_o,
    output logic [7:0] ch3_gain_factor_o,
    output logic chop_enable_o,
    output logic [CHOP_DLY_W-1:0] chop_settle_delay_o,
    input wire logic mod_tick_i,
    input wire logic chop_req_i,
    output logic chop_go_o,
    output logic detect_mode_enable_o,
    output logic detect_channel_rule_o,
    input wire logic conv_tick_i,
    input wire logic [3:0] ch_over_i,
    output logic detect_o,
    output logic window_end_o
);

    // ****************************************
    // Address decoding
    // ****************************************

    // Maps a word address to a store slot; hit is low for unmapped ones.
    function automatic logic [2:0] decode_addr(input logic [3:0] addr);
        if (addr == GAIN_SEL_ADDR) begin
            decode_addr = {1'b1, GAIN_SEL_IDX};
        end else if (addr == SPARE_ADDR) begin
            decode_addr = {1'b1, SPARE_IDX};
        end else if (addr == CHOP_CD_ADDR) begin
            decode_addr = {1'b1, CHOP_CD_IDX};
        end else begin
            decode_addr = 3'h0;
        end
    endfunction

    // Measurement length in conversion periods for a length code.
    function automatic logic [11:0] len_of(input logic [2:0] code);
        case (code)
            3'h0: len_of = CD_LEN_0;
            3'h1: len_of = CD_LEN_1;
            3'h2: len_of = CD_LEN_2;
            3'h3: len_of = CD_LEN_3;
            3'h4: len_of = CD_LEN_4;
            3'h5: len_of = CD_LEN_5;
            3'h6: len_of = CD_LEN_6;
            default: len_of = CD_LEN_7;
        endcase
    endfunction

    logic [2:0] wr_dec;
    logic [2:0] rd_dec;
    logic [DATA_W*REG_COUNT-1:0] words;
    logic [DATA_W-1:0] gain_word;
    logic [DATA_W-1:0] cfg_word;

    // Unmapped writes are dropped and unmapped reads return zero.
    assign wr_dec = decode_addr(reg_addr_i);
    assign rd_dec = decode_addr(reg_addr_i);
    assign gain_word = words[int'(GAIN_SEL_IDX)*DATA_W +: DATA_W];
    assign cfg_word = words[int'(CHOP_CD_IDX)*DATA_W +: DATA_W];

    // ****************************************
    // Register store
    // ****************************************

    // Reserved bits are stored as written; the host keeps them zero.
    cfg_word_store #(
        .WIDTH(DATA_W),
        .DEPTH(REG_COUNT),
        .RST_VALS({CHOP_CD_RST, SPARE_RST, GAIN_SEL_RST})
    ) u_store (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .wr_en_i(reg_wr_i && wr_dec[2]),
        .wr_idx_i(wr_dec[1:0]),
        .wr_data_i(reg_wdata_i),
        .rd_en_i(reg_rd_i && rd_dec[2]),
        .rd_idx_i(rd_dec[1:0]),
        .rd_data_o(reg_rdata_o),
        .words_o(words)
    );

    // ****************************************
    // Field outputs
    // ****************************************

    // Gain codes and factors follow the stored word one cycle later.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ch3_amp_gain_code_o <= '0;
            ch2_amp_gain_code_o <= '0;
            ch1_amp_gain_code_o <= '0;
            ch0_amp_gain_code_o <= '0;
            ch3_gain_factor_o <= GAIN_UNITY;
            ch2_gain_factor_o <= GAIN_UNITY;
            ch1_gain_factor_o <= GAIN_UNITY;
            ch0_gain_factor_o <= GAIN_UNITY;
        end else begin
            ch3_amp_gain_code_o <= gain_word[CH3_GAIN_LSB +: 3];
            ch2_amp_gain_code_o <= gain_word[CH2_GAIN_LSB +: 3];
            ch1_amp_gain_code_o <= gain_word[CH1_GAIN_LSB +: 3];
            ch0_amp_gain_code_o <= gain_word[CH0_GAIN_LSB +: 3];
            ch3_gain_factor_o <= GAIN_UNITY << gain_word[CH3_GAIN_LSB +: 3];
            ch2_gain_factor_o <= GAIN_UNITY << gain_word[CH2_GAIN_LSB +: 3];
            ch1_gain_factor_o <= GAIN_UNITY << gain_word[CH1_GAIN_LSB +: 3];
            ch0_gain_factor_o <= GAIN_UNITY << gain_word[CH0_GAIN_LSB +: 3];
        end
    end

    logic [7:0] need_r;
    logic [11:0] len_r;

    // Chop and detect fields, with the decoded count and length.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            chop_settle_delay_o <= CHOP_CD_RST[CHOP_DLY_LSB +: CHOP_DLY_W];
            chop_enable_o <= CHOP_CD_RST[CHOP_EN_BIT];
            detect_channel_rule_o <= CHOP_CD_RST[CD_RULE_BIT];
            detect_mode_enable_o <= CHOP_CD_RST[DETECT_MODE_ENABLE_BIT];
            need_r <= EXCEED_UNITY;
            len_r <= CD_LEN_0;
        end else begin
            chop_settle_delay_o <= cfg_word[CHOP_DLY_LSB +: CHOP_DLY_W];
            chop_enable_o <= cfg_word[CHOP_EN_BIT];
            detect_channel_rule_o <= cfg_word[CD_RULE_BIT];
            detect_mode_enable_o <= cfg_word[DETECT_MODE_ENABLE_BIT];
            need_r <= EXCEED_UNITY << cfg_word[CD_NUM_LSB +: CD_CODE_W];
            len_r <= len_of(cfg_word[CD_LEN_LSB +: CD_CODE_W]);
        end
    end

    // ****************************************
    // Global-chop settle delay
    // ****************************************
    chop_state_type state_r;
    logic [CHOP_CNT_W-1:0] dly_total_r;
    logic [CHOP_CNT_W-1:0] ticks_r;

    // A request waits 2 << code modulator ticks, then starts measurement.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r <= CHOP_IDLE;
            dly_total_r <= '0;
            ticks_r <= '0;
            chop_go_o <= 1'b0;
        end else begin
            chop_go_o <= 1'b0;
            case (state_r)
                CHOP_IDLE: begin
                    if (chop_req_i && chop_enable_o) begin
                        dly_total_r <= CHOP_DLY_BASE << chop_settle_delay_o;
                        ticks_r <= '0;
                        state_r <= CHOP_WAIT;
                    end
                end
                CHOP_WAIT: begin
                    // Disabling chop abandons a pending wait.
                    if (!chop_enable_o) begin
                        state_r <= CHOP_IDLE;
                    end else if (mod_tick_i) begin
                        if (ticks_r + 17'h00001 == dly_total_r) begin
                            chop_go_o <= 1'b1;
                            state_r <= CHOP_IDLE;
                        end else begin
                            ticks_r <= ticks_r + 17'h00001;
                        end
                    end
                end
                default: begin
                    state_r <= CHOP_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Current detection
    // ****************************************
    logic hit;
    logic [7:0] hits_r;
    logic [11:0] periods_r;

    // Exceedance of one conversion under the channel rule.
    assign hit = detect_channel_rule_o ? (&ch_over_i) : (|ch_over_i);

    // Counts hits inside a window; enough hits end the window early.
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            hits_r <= '0;
            periods_r <= '0;
            detect_o <= 1'b0;
            window_end_o <= 1'b0;
        end else begin
            detect_o <= 1'b0;
            window_end_o <= 1'b0;
            if (!detect_mode_enable_o) begin
                hits_r <= '0;
                periods_r <= '0;
            end else if (conv_tick_i) begin
                if (hit && hits_r + 8'h01 == need_r) begin
                    detect_o <= 1'b1;
                    hits_r <= '0;
                    periods_r <= '0;
                end else if (periods_r + 12'h001 >= len_r) begin
                    window_end_o <= 1'b1;
                    hits_r <= '0;
                    periods_r <= '0;
                end else begin
                    hits_r <= hits_r + {7'h00, hit};
                    periods_r <= periods_r + 12'h001;
                end
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    ch3_gain_follow_a: assert property (
        reg_wr_i && reg_addr_i == GAIN_SEL_ADDR |=> ##1
        ch3_gain_factor_o == (GAIN_UNITY << $past(reg_wdata_i[14:12], 2)))
        else $error("channel 3 gain factor wrong after write");
    ch2_gain_follow_a: assert property (
        reg_wr_i && reg_addr_i == GAIN_SEL_ADDR |=> ##1
        ch2_amp_gain_code_o == $past(reg_wdata_i[10:8], 2))
        else $error("channel 2 gain code wrong after write");
    ch1_gain_follow_a: assert property (
        reg_wr_i && reg_addr_i == GAIN_SEL_ADDR |=> ##1
        ch1_gain_factor_o == (GAIN_UNITY << $past(reg_wdata_i[6:4], 2)))
        else $error("channel 1 gain factor wrong after write");
    ch0_gain_follow_a: assert property (
        reg_wr_i && reg_addr_i == GAIN_SEL_ADDR |=> ##1
        ch0_amp_gain_code_o == $past(reg_wdata_i[2:0], 2))
        else $error("channel 0 gain code wrong after write");
    gain_readback_a: assert property (
        reg_rd_i && reg_addr_i == GAIN_SEL_ADDR |=>
        reg_rdata_o == $past(gain_word))
        else $error("gain register read returned wrong data");
    cfg_fields_a: assert property (
        ##1 chop_enable_o == $past(cfg_word[8]) &&
        chop_settle_delay_o == $past(cfg_word[12:9]))
        else $error("chop fields do not follow the config word");
    chop_delay_a: assert property (
        chop_go_o |-> $past(mod_tick_i) &&
        dly_total_r == (CHOP_DLY_BASE << chop_settle_delay_o) &&
        ticks_r + 17'h00001 == dly_total_r)
        else $error("chop measurement started after wrong delay");
    detect_rule_a: assert property (
        detect_o |-> $past(conv_tick_i) && ($past(detect_channel_rule_o) ?
        $past(&ch_over_i) : $past(|ch_over_i)))
        else $error("detection without qualifying channels");
    detect_count_a: assert property (
        detect_o |-> $past(hits_r) + 8'h01 == $past(need_r) &&
        hits_r == 8'h00)
        else $error("detection at wrong exceedance count");
    window_len_a: assert property (
        window_end_o |-> $past(periods_r) + 12'h001 >= $past(len_r) &&
        periods_r == 12'h000)
        else $error("detect window ended at wrong length");
    write_readback_a: assert property (
        reg_wr_i && wr_dec[2] ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i)
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("read did not return last written value");
    unmapped_zero_a: assert property (
        reg_rd_i && !rd_dec[2] |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read returned nonzero data");

endmodule // adc_gain_chop_regs

// ### verif/host_port_model.sv
// Host side of the register port: issues one-cycle write and read strobes.
// Assumes the block answers a read with data in the following cycle only.
`timescale 1ns/1ps
module host_port_model
    import adc_cfg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic [DATA_W-1:0] reg_rdata_i,
    output logic [ADDR_W-1:0] reg_addr_o,
    output logic [DATA_W-1:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    // ****************************************
    // Bus idle state
    // ****************************************
    // The port is quiet from time zero until the first access.
    initial begin
        reg_addr_o = 4'h0;
        reg_wdata_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // ****************************************
    // Access tasks
    // ****************************************
    // One write cycle; reserved bits of the gain and spare words are forced low as a real host must.
    task automatic write_word(input logic [ADDR_W-1:0] addr,
                              input logic [DATA_W-1:0] data);
        logic [DATA_W-1:0] d;
        begin
            d = data;
            if (addr == GAIN_SEL_ADDR) d = data & 16'h7777;
            if (addr == SPARE_ADDR) d = 16'h0000;
            @(posedge core_clk_i);
            reg_addr_o <= addr;
            reg_wdata_o <= d;
            reg_wr_o <= 1'b1;
            @(posedge core_clk_i);
            reg_wr_o <= 1'b0;
        end
    endtask

    // One read cycle; data is taken in the cycle after the strobe.
    task automatic read_word(input logic [ADDR_W-1:0] addr,
                             output logic [DATA_W-1:0] data);
        begin
            @(posedge core_clk_i);
            reg_addr_o <= addr;
            reg_rd_o <= 1'b1;
            @(posedge core_clk_i);
            reg_rd_o <= 1'b0;
            #1;
            data = reg_rdata_i;
        end
    endtask

    // A write and a read of the same word back to back, with no gap.
    task automatic write_read(input logic [ADDR_W-1:0] addr,
                              input logic [DATA_W-1:0] data,
                              output logic [DATA_W-1:0] rdata);
        logic [DATA_W-1:0] d;
        begin
            d = data;
            if (addr == GAIN_SEL_ADDR) d = data & 16'h7777;
            if (addr == SPARE_ADDR) d = 16'h0000;
            @(posedge core_clk_i);
            reg_addr_o <= addr;
            reg_wdata_o <= d;
            reg_wr_o <= 1'b1;
            @(posedge core_clk_i);
            reg_wr_o <= 1'b0;
            reg_rd_o <= 1'b1;
            @(posedge core_clk_i);
            reg_rd_o <= 1'b0;
            #1;
            rdata = reg_rdata_i;
        end
    endtask
endmodule // host_port_model

// ### verif/adc_gain_and_chop_config_regs_tb_top.sv
// Self-checking bench for the gain, chop and current-detect registers.
// Assumes the host model drives the register port and the bench the ticks.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module adc_gain_and_chop_config_regs_tb_top
    import adc_cfg_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic mod_tick = 1'b0;
    logic chop_req = 1'b0;
    logic conv_tick = 1'b0;
    logic [3:0] ch_over = 4'h0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic wr, rdst, chop_go, det, wend, cen, den, rule;
    logic [2:0] gc [4];
    logic [7:0] gf [4];
    logic [3:0] dly;
    int fails = 0;
    int total_checks = 0;

    // ****************************************
    // Clock, design and host
    // ****************************************
    // A 100 ns clock period.
    always #50 core_clk_i = ~core_clk_i;

    adc_gain_chop_regs u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rdst), .reg_rdata_o(rdata),
        .ch0_amp_gain_code_o(gc[0]), .ch1_amp_gain_code_o(gc[1]),
        .ch2_amp_gain_code_o(gc[2]), .ch3_amp_gain_code_o(gc[3]),
        .ch0_gain_factor_o(gf[0]), .ch1_gain_factor_o(gf[1]),
        .ch2_gain_factor_o(gf[2]), .ch3_gain_factor_o(gf[3]),
        .chop_enable_o(cen), .chop_settle_delay_o(dly),
        .mod_tick_i(mod_tick), .chop_req_i(chop_req), .chop_go_o(chop_go),
        .detect_mode_enable_o(den), .detect_channel_rule_o(rule),
        .conv_tick_i(conv_tick), .ch_over_i(ch_over), .detect_o(det),
        .window_end_o(wend));

    host_port_model u_host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
        .reg_rd_o(rdst));

    // ****************************************
    // Helper tasks
    // ****************************************
    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Holds reset for two cycles.
    task automatic do_reset();
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        #1;
    endtask

    // Requests a chop start with a steady tick train; counts ticks to go.
    task automatic chop_run(input logic [3:0] code, input logic en,
                            input int exp_cnt);
        int cnt;
        begin
            u_host.write_word(CHOP_CD_ADDR, {3'h0, code, en, 8'h00});
            @(posedge core_clk_i);
            chop_req <= 1'b1;
            @(posedge core_clk_i);
            chop_req <= 1'b0;
            mod_tick <= 1'b1;
            cnt = 0;
            while (cnt < 20 && chop_go !== 1'b1) begin
                @(posedge core_clk_i);
                #1;
                cnt++;
            end
            mod_tick <= 1'b0;
            `CHK(cnt, exp_cnt)
            @(posedge core_clk_i);
            #1;
            `CHK(chop_go, 1'b0)
        end
    endtask

    // Streams conversion ticks until a detection or a window end.
    task automatic det_run(input logic [15:0] cfg, input logic [3:0] over,
                           input int exp_cnt, input logic exp_det);
        int cnt;
        begin
            u_host.write_word(CHOP_CD_ADDR, cfg);
            @(posedge core_clk_i);
            conv_tick <= 1'b1;
            ch_over <= over;
            cnt = 0;
            while (cnt < 300 && det !== 1'b1 && wend !== 1'b1) begin
                @(posedge core_clk_i);
                #1;
                cnt++;
            end
            conv_tick <= 1'b0;
            `CHK(cnt, exp_cnt)
            `CHK(det, exp_det)
            `CHK(wend, ~exp_det)
        end
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    // The sequence needs about 530 cycles; 15000, near thirty times that, means a hang.
    initial begin
        repeat (15000) @(posedge core_clk_i);
        fails++;
        end_sim();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    // Reset values, gain fields, refusals, chop and detect timing.
    initial begin
        logic [2:0] g [4];
        logic [15:0] w;
        do_reset();
        u_host.read_word(GAIN_SEL_ADDR, rd);
        `CHK(rd, GAIN_SEL_RST)
        u_host.read_word(SPARE_ADDR, rd);
        `CHK(rd, SPARE_RST)
        u_host.read_word(CHOP_CD_ADDR, rd);
        `CHK(rd, CHOP_CD_RST)
        `CHK(dly, 4'h3)
        `CHK({cen, den, rule}, 3'h0)
        for (int i = 0; i < 4; i++) `CHK(gf[i], 8'h01)
        for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < 4; i++) g[i] = 3'(c + i);
            w = {1'b0, g[3], 1'b0, g[2], 1'b0, g[1], 1'b0, g[0]};
            u_host.write_word(GAIN_SEL_ADDR, w);
            @(posedge core_clk_i);
            #1;
            for (int i = 0; i < 4; i++) begin
                `CHK(gc[i], g[i])
                `CHK(gf[i], 8'h01 << g[i])
            end
            u_host.read_word(GAIN_SEL_ADDR, rd);
            `CHK(rd, w)
        end
        // Unmapped address: write dropped, read gives zero.
        u_host.write_word(4'h0, 16'hFFFF);
        u_host.read_word(4'h0, rd);
        `CHK(rd, 16'h0000)
        u_host.read_word(GAIN_SEL_ADDR, rd);
        `CHK(rd, w)
        // A read straight after the write must see the new word.
        u_host.write_read(CHOP_CD_ADDR, 16'h1FFF, rd);
        `CHK(rd, 16'h1FFF)
        `CHK({dly, cen, rule, den}, 7'h7F)
        chop_run(4'h0, 1'b1, 2);
        chop_run(4'h1, 1'b1, 4);
        chop_run(4'h3, 1'b1, 16);
        chop_run(4'h3, 1'b0, 20);
        det_run(16'h0611, 4'h4, 2, 1'b1);
        det_run(16'h0621, 4'h8, 4, 1'b1);
        det_run(16'h0681, 4'h7, 128, 1'b0);
        det_run(16'h0681, 4'hF, 1, 1'b1);
        det_run(16'h0603, 4'h0, 256, 1'b0);
        // A second reset restores the documented values.
        do_reset();
        u_host.read_word(CHOP_CD_ADDR, rd);
        `CHK(rd, CHOP_CD_RST)
        u_host.read_word(GAIN_SEL_ADDR, rd);
        `CHK(rd, GAIN_SEL_RST)
        end_sim();
    end
endmodule // adc_gain_and_chop_config_regs_tb_top
